/* File: core/scp_pkg.sv */
// Purpose: shared constants and types for the serial command port ends
// Assumes: frame counts are rising edges of the link clock after select
// Notes:   header is eight bits, read word five bits, write word eight bits
`default_nettype none

package scp_pkg;

    // field widths
    localparam int unsigned SCP_ADDR_W    = 4;
    localparam int unsigned SCP_RDATA_W   = 5;
    localparam int unsigned SCP_WDATA_W   = 8;
    localparam int unsigned SCP_HDR_BITS  = 8;
    localparam int unsigned SCP_FRAME_W   = SCP_HDR_BITS + SCP_WDATA_W;
    localparam int unsigned SCP_REG_COUNT = 16;
    localparam int unsigned SCP_CNT_W     = 5;

    // rising-edge numbers within a frame
    localparam logic [4:0] SCP_RW_EDGE       = 5'h01;
    localparam logic [4:0] SCP_ADDR_FIRST    = 5'h02;
    localparam logic [4:0] SCP_ADDR_LAST     = 5'h05;
    localparam logic [4:0] SCP_RD_FETCH      = 5'h06;
    localparam logic [4:0] SCP_RD_FIRST      = 5'h08;
    localparam logic [4:0] SCP_RD_LAST       = 5'h0C;
    localparam logic [4:0] SCP_RD_OFF        = 5'h0D;
    localparam logic [4:0] SCP_WR_FIRST      = 5'h09;
    localparam logic [4:0] SCP_WR_LAST       = 5'h10;
    localparam logic [4:0] SCP_CNT_SAT       = 5'h11;

    // host sample window for the read word
    localparam logic [4:0] SCP_HRD_FIRST     = 5'h09;
    localparam logic [4:0] SCP_HRD_LAST      = 5'h0D;

    // values after reset
    localparam logic [4:0] SCP_REG_RST       = 5'h00;
    localparam logic [4:0] SCP_CNT_RST       = 5'h00;
    localparam logic [7:0] SCP_DIV_RST       = 8'h00;

    // default half period of the host-made link clock, in system cycles
    localparam int unsigned SCP_HALF_DEF     = 4;

    // host sequencer states
    typedef enum logic [1:0] {
        SCP_H_IDLE  = 2'b00,
        SCP_H_WAIT  = 2'b01,
        SCP_H_SHIFT = 2'b10
    } scp_hst_t;

endpackage : scp_pkg

`default_nettype wire

/* File: core/scp_if.sv */
// Purpose: the four-wire link between host and device ends
// Assumes: the bench merges the two data wires if it ties them together
// Notes:   serial_port_out is meaningful only while its enable is high
`default_nettype none

interface scp_if;
    logic chip_select_n;      // active-low select, host driven
    logic sclk;               // link clock, host driven
    logic serial_port_in;     // data into the device
    logic serial_port_out;    // data out of the device
    logic serial_port_out_oe; // device drives serial_port_out while high

    modport dev (
        input  chip_select_n,
        input  sclk,
        input  serial_port_in,
        output serial_port_out,
        output serial_port_out_oe
    );

    modport host (
        output chip_select_n,
        output sclk,
        output serial_port_in,
        input  serial_port_out,
        input  serial_port_out_oe
    );
endinterface : scp_if

`default_nettype wire

/* File: core/scp_dev_end.sv */
// Purpose: device end of the serial command port, holding command registers
// Assumes: link clock comes from the host; i_sys_clk is unrelated in phase
// Notes:   register writes are reported to the system clock domain
//
// Behaviour
// R1 - exactly four wires: select, clock, in, out
// R2 - host runs clock before lowering select
// R3 - transactions only while select is low
// R4 - eight header bits precede any data
// R5 - header bits sampled on rising clock edges
// R6 - first header bit: one read, zero write
// R7 - next four bits: address, LSB first
// R8 - bits six, seven zero; bit eight ignored
// R9 - read: three idle, five bits on falls, tri-state
// R10 - write: eight bits LSB first on rises
// R11 - select high abandons frame, counter restarts
`default_nettype none

module scp_dev_end #(
    parameter int unsigned REG_COUNT = scp_pkg::SCP_REG_COUNT
) (
    input  wire logic                             i_sys_clk,
    input  wire logic                             i_rstn,
    scp_if.dev                                    link,
    output logic                                  o_wr_strobe,
    output logic [scp_pkg::SCP_ADDR_W-1:0]        o_wr_addr,
    output logic [scp_pkg::SCP_WDATA_W-1:0]       o_wr_data
);
    import scp_pkg::*;

    // frame state is held in reset while select is high
    logic xact_rstn;
    assign xact_rstn = i_rstn & ~link.chip_select_n; // R3 R11

    // rising-edge frame state
    logic [SCP_CNT_W-1:0]   edge_cnt_ff;
    logic [SCP_CNT_W-1:0]   nxt_edge_cnt;
    logic                   rd_op_ff;
    logic                   nxt_rd_op;
    logic [SCP_ADDR_W-1:0]  addr_ff;
    logic [SCP_ADDR_W-1:0]  nxt_addr;
    logic [SCP_WDATA_W-1:0] wsh_ff;
    logic [SCP_WDATA_W-1:0] nxt_wsh;
    logic [SCP_RDATA_W-1:0] rword_ff;
    logic [SCP_RDATA_W-1:0] nxt_rword;
    logic [SCP_CNT_W-1:0]   edge_num;
    logic                   commit;

    // register bank and write report, kept across frames
    logic [SCP_RDATA_W-1:0] bank_ff [REG_COUNT];
    logic [SCP_RDATA_W-1:0] nxt_bank [REG_COUNT];
    logic                   wr_tgl_ff;
    logic                   nxt_wr_tgl;
    logic [SCP_ADDR_W-1:0]  wr_addr_ff;
    logic [SCP_ADDR_W-1:0]  nxt_wr_addr;
    logic [SCP_WDATA_W-1:0] wr_data_ff;
    logic [SCP_WDATA_W-1:0] nxt_wr_data;

    // falling-edge output state
    logic                   sdo_ff;
    logic                   nxt_sdo;
    logic                   oe_ff;
    logic                   nxt_oe;
    logic [SCP_RDATA_W-1:0] rd_sh_ff;
    logic [SCP_RDATA_W-1:0] nxt_rd_sh;

    // system-domain side of the write report
    logic                   tgl_s1_ff;
    logic                   tgl_s2_ff;
    logic                   tgl_s3_ff;
    logic                   strobe_ff;
    logic [SCP_ADDR_W-1:0]  sys_addr_ff;
    logic [SCP_WDATA_W-1:0] sys_data_ff;
    logic                   nxt_strobe;
    logic [SCP_ADDR_W-1:0]  nxt_sys_addr;
    logic [SCP_WDATA_W-1:0] nxt_sys_data;

    // next frame state on each rising edge of the link clock
    always_comb begin
        edge_num     = edge_cnt_ff + 5'h01; // number of the edge now arriving
        nxt_edge_cnt = edge_cnt_ff;
        nxt_rd_op    = rd_op_ff;
        nxt_addr     = addr_ff;
        nxt_wsh      = wsh_ff;
        nxt_rword    = rword_ff;
        commit       = 1'b0;
        if (edge_cnt_ff != SCP_CNT_SAT) begin
            nxt_edge_cnt = edge_num; // R4
        end
        if (edge_num == SCP_RW_EDGE) begin
            nxt_rd_op = link.serial_port_in; // R5 R6
        end
        if ((edge_num >= SCP_ADDR_FIRST) && (edge_num <= SCP_ADDR_LAST)) begin
            nxt_addr = {link.serial_port_in, addr_ff[SCP_ADDR_W-1:1]}; // R7 R8
        end
        // header bits six to eight carry nothing for the device
        if (edge_num == SCP_RD_FETCH) begin
            nxt_rword = bank_ff[addr_ff]; // R7 R9
        end
        if (!rd_op_ff && (edge_num >= SCP_WR_FIRST) && (edge_num <= SCP_WR_LAST)) begin
            nxt_wsh = {link.serial_port_in, wsh_ff[SCP_WDATA_W-1:1]}; // R10
            if (edge_num == SCP_WR_LAST) begin
                commit = 1'b1;
            end
        end
    end

    // frame state registers, cleared whenever select rises
    always_ff @(posedge link.sclk or negedge xact_rstn) begin
        if (!xact_rstn) begin
            edge_cnt_ff <= SCP_CNT_RST; // R11
            rd_op_ff    <= 1'b0;
            addr_ff     <= '0;
            wsh_ff      <= '0;
            rword_ff    <= SCP_REG_RST;
        end else begin
            edge_cnt_ff <= nxt_edge_cnt;
            rd_op_ff    <= nxt_rd_op;
            addr_ff     <= nxt_addr;
            wsh_ff      <= nxt_wsh;
            rword_ff    <= nxt_rword;
        end
    end

    // bank update and write report on the last data edge
    always_comb begin
        nxt_bank    = bank_ff;
        nxt_wr_tgl  = wr_tgl_ff;
        nxt_wr_addr = wr_addr_ff;
        nxt_wr_data = wr_data_ff;
        if (commit) begin
            nxt_bank[addr_ff] = nxt_wsh[SCP_RDATA_W-1:0]; // R10
            nxt_wr_tgl        = ~wr_tgl_ff;
            nxt_wr_addr       = addr_ff;
            nxt_wr_data       = nxt_wsh;
        end
    end

    // bank registers survive select changes
    always_ff @(posedge link.sclk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                bank_ff[i] <= SCP_REG_RST;
            end
            wr_tgl_ff  <= 1'b0;
            wr_addr_ff <= '0;
            wr_data_ff <= '0;
        end else begin
            bank_ff    <= nxt_bank;
            wr_tgl_ff  <= nxt_wr_tgl;
            wr_addr_ff <= nxt_wr_addr;
            wr_data_ff <= nxt_wr_data;
        end
    end

    // read word out on falling edges after the idle period
    always_comb begin
        nxt_sdo   = sdo_ff;
        nxt_oe    = oe_ff;
        nxt_rd_sh = rd_sh_ff;
        if (rd_op_ff) begin
            if (edge_cnt_ff == SCP_RD_FIRST) begin
                nxt_oe    = 1'b1; // R9
                nxt_sdo   = rword_ff[0];
                nxt_rd_sh = {1'b0, rword_ff[SCP_RDATA_W-1:1]};
            end else if ((edge_cnt_ff > SCP_RD_FIRST) && (edge_cnt_ff <= SCP_RD_LAST)) begin
                nxt_sdo   = rd_sh_ff[0]; // R9
                nxt_rd_sh = {1'b0, rd_sh_ff[SCP_RDATA_W-1:1]};
            end else if (edge_cnt_ff == SCP_RD_OFF) begin
                nxt_oe  = 1'b0; // R9
                nxt_sdo = 1'b0;
            end
        end
    end

    // output registers on the falling edge; select high releases the pin
    always_ff @(negedge link.sclk or negedge xact_rstn) begin
        if (!xact_rstn) begin
            sdo_ff   <= 1'b0; // R11
            oe_ff    <= 1'b0;
            rd_sh_ff <= '0;
        end else begin
            sdo_ff   <= nxt_sdo;
            oe_ff    <= nxt_oe;
            rd_sh_ff <= nxt_rd_sh;
        end
    end

    assign link.serial_port_out    = sdo_ff;
    assign link.serial_port_out_oe = oe_ff; // R1

    // write report crosses by toggle; data is steady long before it is seen
    always_comb begin
        nxt_strobe   = tgl_s2_ff ^ tgl_s3_ff;
        nxt_sys_addr = sys_addr_ff;
        nxt_sys_data = sys_data_ff;
        if (tgl_s2_ff ^ tgl_s3_ff) begin
            nxt_sys_addr = wr_addr_ff;
            nxt_sys_data = wr_data_ff;
        end
    end

    // system-domain synchroniser and report registers
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tgl_s1_ff   <= 1'b0;
            tgl_s2_ff   <= 1'b0;
            tgl_s3_ff   <= 1'b0;
            strobe_ff   <= 1'b0;
            sys_addr_ff <= '0;
            sys_data_ff <= '0;
        end else begin
            tgl_s1_ff   <= wr_tgl_ff;
            tgl_s2_ff   <= tgl_s1_ff;
            tgl_s3_ff   <= tgl_s2_ff;
            strobe_ff   <= nxt_strobe;
            sys_addr_ff <= nxt_sys_addr;
            sys_data_ff <= nxt_sys_data;
        end
    end

    assign o_wr_strobe = strobe_ff;
    assign o_wr_addr   = sys_addr_ff;
    assign o_wr_data   = sys_data_ff;

endmodule : scp_dev_end

`default_nettype wire

/* File: core/scp_host_end.sv */
// Purpose: host end of the serial command port, one command at a time
// Assumes: HALF of at least 3 so the read bit is settled when sampled
// Notes:   link clock is divided from i_sys_clk and runs without pause
`default_nettype none

module scp_host_end #(
    parameter int unsigned HALF = scp_pkg::SCP_HALF_DEF
) (
    input  wire logic                             i_sys_clk,
    input  wire logic                             i_rstn,
    scp_if.host                                   link,
    input  wire logic                             i_req,
    input  wire logic                             i_rd,
    input  wire logic [scp_pkg::SCP_ADDR_W-1:0]   i_addr,
    input  wire logic [scp_pkg::SCP_WDATA_W-1:0]  i_wdata,
    output logic                                  o_busy,
    output logic                                  o_done,
    output logic [scp_pkg::SCP_RDATA_W-1:0]       o_rdata
);
    import scp_pkg::*;

    scp_hst_t               st_ff, nxt_st;
    logic [7:0]             div_ff, nxt_div;
    logic                   sclk_ff, nxt_sclk;
    logic                   cs_n_ff, nxt_cs_n;
    logic                   sdi_ff, nxt_sdi;
    logic [SCP_CNT_W-1:0]   cnt_ff, nxt_cnt;
    logic [SCP_FRAME_W-1:0] frame_ff, nxt_frame;
    logic                   rd_ff, nxt_rd;
    logic [SCP_RDATA_W-1:0] rdata_ff, nxt_rdata;
    logic                   busy_ff, nxt_busy;
    logic                   done_ff, nxt_done;
    logic                   sdo_s1_ff, sdo_s2_ff;
    logic                   tick, rise, fall;
    logic [SCP_CNT_W-1:0]   rise_num;

    // divider, frame sequencer and read sampling
    always_comb begin
        tick      = (div_ff == 8'(HALF - 1));
        rise      = tick & ~sclk_ff;
        fall      = tick & sclk_ff;
        rise_num  = cnt_ff + 5'h01;
        nxt_div   = tick ? SCP_DIV_RST : div_ff + 8'h01;
        nxt_sclk  = tick ? ~sclk_ff : sclk_ff; // R2
        nxt_st    = st_ff;
        nxt_cs_n  = cs_n_ff;
        nxt_sdi   = sdi_ff;
        nxt_cnt   = cnt_ff;
        nxt_frame = frame_ff;
        nxt_rd    = rd_ff;
        nxt_rdata = rdata_ff;
        nxt_busy  = busy_ff;
        nxt_done  = 1'b0;
        case (st_ff)
            SCP_H_IDLE: begin
                if (i_req) begin
                    nxt_frame = {i_wdata, 3'h0, i_addr, i_rd}; // R6 R7 R8
                    nxt_rd    = i_rd;
                    nxt_busy  = 1'b1;
                    nxt_st    = SCP_H_WAIT;
                end
            end
            SCP_H_WAIT: begin
                if (fall) begin
                    nxt_cs_n = 1'b0; // R3
                    nxt_sdi  = frame_ff[0];
                    nxt_cnt  = SCP_CNT_RST;
                    nxt_st   = SCP_H_SHIFT;
                end
            end
            SCP_H_SHIFT: begin
                if (rise) begin
                    nxt_cnt = rise_num; // R4
                    if (rd_ff && (rise_num >= SCP_HRD_FIRST) && (rise_num <= SCP_HRD_LAST)) begin
                        nxt_rdata = {sdo_s2_ff, rdata_ff[SCP_RDATA_W-1:1]}; // R9
                    end
                end else if (fall) begin
                    if (cnt_ff == (rd_ff ? SCP_HRD_LAST : SCP_WR_LAST)) begin
                        nxt_cs_n = 1'b1; // R11
                        nxt_sdi  = 1'b0;
                        nxt_busy = 1'b0;
                        nxt_done = 1'b1;
                        nxt_st   = SCP_H_IDLE;
                    end else begin
                        nxt_sdi = frame_ff[cnt_ff[3:0]]; // R10
                    end
                end
            end
            default: begin
                nxt_st = SCP_H_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff    <= SCP_H_IDLE;
            div_ff   <= SCP_DIV_RST;
            sclk_ff  <= 1'b0;
            cs_n_ff  <= 1'b1;
            sdi_ff   <= 1'b0;
            cnt_ff   <= SCP_CNT_RST;
            frame_ff <= '0;
            rd_ff    <= 1'b0;
            rdata_ff <= SCP_REG_RST;
            busy_ff  <= 1'b0;
            done_ff  <= 1'b0;
        end else begin
            st_ff    <= nxt_st;
            div_ff   <= nxt_div;
            sclk_ff  <= nxt_sclk;
            cs_n_ff  <= nxt_cs_n;
            sdi_ff   <= nxt_sdi;
            cnt_ff   <= nxt_cnt;
            frame_ff <= nxt_frame;
            rd_ff    <= nxt_rd;
            rdata_ff <= nxt_rdata;
            busy_ff  <= nxt_busy;
            done_ff  <= nxt_done;
        end
    end

    // two-flop synchroniser on the returning data pin
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sdo_s1_ff <= 1'b0;
            sdo_s2_ff <= 1'b0;
        end else begin
            sdo_s1_ff <= link.serial_port_out;
            sdo_s2_ff <= sdo_s1_ff;
        end
    end

    assign link.sclk           = sclk_ff; // R1
    assign link.chip_select_n  = cs_n_ff;
    assign link.serial_port_in = sdi_ff;
    assign o_busy              = busy_ff;
    assign o_done              = done_ff;
    assign o_rdata             = rdata_ff;

endmodule : scp_host_end

`default_nettype wire

/* File: verif/scp_link_sva.sv */
// Purpose: link checker for the serial command port
// Assumes: edge count is rising sclk edges already seen in the frame
// Notes:   frame state clears while select is high
`default_nettype none

module scp_link_sva (
    input wire logic i_rstn,
    input wire logic chip_select_n,
    input wire logic sclk,
    input wire logic serial_port_in,
    input wire logic serial_port_out,
    input wire logic serial_port_out_oe
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    logic       rd_ff;
    logic       nxt_rd;

    default clocking cb_link @(posedge sclk);
    endclocking
    default disable iff (!i_rstn);

    // edge count and operation flag of the running frame
    always_comb begin
        nxt_cnt = (cnt_ff == 5'h1F) ? cnt_ff : cnt_ff + 5'h01;
        nxt_rd  = (cnt_ff == 5'h00) ? serial_port_in : rd_ff;
    end

    // select high clears the frame at once, as in the device
    always_ff @(posedge sclk or posedge chip_select_n or negedge i_rstn) begin
        if (!i_rstn || chip_select_n) begin
            cnt_ff <= 5'h00;
            rd_ff  <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            rd_ff  <= nxt_rd;
        end
    end

    // frame starts and lengths
    sequence s_rd_start;
        $fell(chip_select_n) && serial_port_in;
    endsequence
    sequence s_wr_start;
        $fell(chip_select_n) && !serial_port_in;
    endsequence
    sequence s_low8;
        !chip_select_n [*8];
    endsequence

    chk_oe_idle_select: assert property (
        chip_select_n |-> !serial_port_out_oe) else $error("output enabled without select");
    chk_rd_idle: assert property (
        !chip_select_n && rd_ff && cnt_ff >= 5'h01 && cnt_ff <= 5'h07 |-> !serial_port_out_oe)
        else $error("read output early");
    chk_oe_onset: assert property (
        !chip_select_n && rd_ff && cnt_ff == 5'h08 |-> $rose(serial_port_out_oe))
        else $error("read output not started after edge 8");
    chk_rd_drive: assert property (
        !chip_select_n && rd_ff && cnt_ff >= 5'h08 && cnt_ff <= 5'h0C |-> serial_port_out_oe)
        else $error("read output dropped early");
    chk_wr_quiet: assert property (
        !chip_select_n && !rd_ff && cnt_ff != 5'h00 |-> !serial_port_out_oe)
        else $error("output driven in a write");
    chk_sdo_quiet: assert property (
        !serial_port_out_oe |-> !serial_port_out) else $error("data out while released");
    chk_hdr_pad: assert property (
        !chip_select_n && (cnt_ff == 5'h05 || cnt_ff == 5'h06) |-> !serial_port_in)
        else $error("header pad bit not zero");
    chk_rd_frame: assert property (
        s_rd_start |-> s_low8 ##1 !chip_select_n [*5] ##1 chip_select_n)
        else $error("read frame length wrong");
    chk_wr_frame: assert property (
        s_wr_start |-> s_low8 ##1 s_low8 ##1 chip_select_n) else $error("write frame length wrong");
endmodule : scp_link_sva

`default_nettype wire

/* File: verif/serial_command_port_header_tb.sv */
// Purpose: bench for host and device ends of the serial command port
// Assumes: second device end is driven by a bench link at 160 ns
// Notes:   second link tests select-high noise, aborts and wire order
`default_nettype none

module serial_command_port_header_tb import scp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic        i_sys_clk, i_rstn, i_req, i_rd, o_busy, o_done;
    logic        o_wr_strobe, o_wr_strobe_b;
    logic [3:0]  i_addr, o_wr_addr, o_wr_addr_b;
    logic [7:0]  i_wdata, o_wr_data, o_wr_data_b, lfsr;
    logic [4:0]  o_rdata, rd5;
    logic [5:0]  note, oe6;
    logic [7:0]  mem [16];
    logic [12:0] wr_q [$];
    logic [12:0] wr_b_q [$];
    logic [5:0]  hq [$];
    int          error_cnt, checks, cyc, a;

    scp_if link();
    scp_if link_b();

    scp_host_end #(.HALF(SCP_HALF_DEF)) u_scp_host_end (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
        .link(link), .i_req(i_req), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
        .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata));
    scp_dev_end #(.REG_COUNT(SCP_REG_COUNT)) u_scp_dev_end (.i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn), .link(link), .o_wr_strobe(o_wr_strobe), .o_wr_addr(o_wr_addr),
        .o_wr_data(o_wr_data));
    scp_dev_end #(.REG_COUNT(SCP_REG_COUNT)) u_scp_dev_end_b (.i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn), .link(link_b), .o_wr_strobe(o_wr_strobe_b), .o_wr_addr(o_wr_addr_b),
        .o_wr_data(o_wr_data_b));
    scp_link_sva u_scp_link_sva (.i_rstn(i_rstn), .chip_select_n(link.chip_select_n),
        .sclk(link.sclk), .serial_port_in(link.serial_port_in),
        .serial_port_out(link.serial_port_out), .serial_port_out_oe(link.serial_port_out_oe));

    // system clock
    initial begin
        i_sys_clk = 1'b0;
        forever #50 i_sys_clk = ~i_sys_clk;
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    task automatic check_eq(input logic [12:0] seen, input logic [12:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check_eq

    task automatic complete_run();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    // one host command; a second request while busy must be ignored
    task automatic host_cmd(input logic rd, input logic [3:0] addr, input logic [7:0] data);
        int n;
        n = 0;
        hq.push_back({rd, data[4:0]});
        if (!rd) wr_q.push_back(13'({addr, data}));
        i_req   <= 1'b1;
        i_rd    <= rd;
        i_addr  <= addr;
        i_wdata <= data;
        @(posedge i_sys_clk);
        i_rd    <= ~rd;
        i_addr  <= ~addr;
        i_wdata <= ~data;
        @(posedge i_sys_clk);
        i_req <= 1'b0;
        while (o_busy !== 1'b0 && n < 400) begin
            @(posedge i_sys_clk);
            n++;
        end
        check_eq(13'(n < 400), 13'h0001);
    endtask : host_cmd

    // bench link frame; sclk runs only inside it, sel low keeps select high
    task automatic link_frame(input logic sel, input int n, input logic [15:0] bits);
        int i;
        rd5 = 5'h00;
        oe6 = 6'h00;
        // one clock period with select high before the frame starts
        link_b.sclk = 1'b1;
        #80 link_b.sclk = 1'b0;
        #80 link_b.chip_select_n = ~sel;
        link_b.serial_port_in = bits[0];
        for (i = 1; i <= n; i++) begin
            #80 link_b.sclk = 1'b1;
            if (i >= 9 && i <= 13) rd5[i-9] = link_b.serial_port_out;
            if (i >= 9 && i <= 14) oe6[i-9] = link_b.serial_port_out_oe;
            #80 link_b.sclk = 1'b0;
            link_b.serial_port_in = (i < 16) ? bits[i] : ~bits[15];
        end
        #80 link_b.chip_select_n = 1'b1;
        link_b.serial_port_in = ~link_b.serial_port_in;
        #80;
    endtask : link_frame

    // compare reports and completions with the oldest note
    always @(posedge i_sys_clk) begin
        if (o_wr_strobe === 1'b1) begin
            check_eq(13'(wr_q.size() != 0), 13'h0001);
            if (wr_q.size() != 0) begin
                check_eq(13'({o_wr_addr, o_wr_data}), wr_q.pop_front());
            end
        end
        if (o_wr_strobe_b === 1'b1) begin
            check_eq(13'(wr_b_q.size() != 0), 13'h0001);
            if (wr_b_q.size() != 0) begin
                check_eq(13'({o_wr_addr_b, o_wr_data_b}), wr_b_q.pop_front());
            end
        end
        if (o_done === 1'b1) begin
            check_eq(13'(hq.size() != 0), 13'h0001);
            if (hq.size() != 0) begin
                note = hq.pop_front();
                if (note[5]) check_eq(13'(o_rdata), 13'(note[4:0]));
            end
        end
    end

    // hang guard
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            $display("Error at %0t: timeout", $time);
            error_cnt++;
            complete_run();
        end
    end

    // main sequence
    initial begin
        {i_req, i_rd, i_addr, i_wdata} = '0;
        i_rstn = 1'b1;
        {link_b.chip_select_n, link_b.sclk, link_b.serial_port_in} = 3'b100;
        {error_cnt, checks, cyc} = '0;
        lfsr = 8'h2B;
        // a real falling edge of reset, so every asynchronous reset sees it
        @(posedge i_sys_clk);
        i_rstn <= 1'b0;
        repeat (8) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        @(posedge i_sys_clk);
        for (a = 0; a < 16; a++) begin
            lfsr = lfsr_next(lfsr);
            mem[a] = lfsr;
            host_cmd(1'b0, 4'(a), lfsr);
        end
        for (a = 15; a >= 0; a--) host_cmd(1'b1, 4'(a), mem[a]);
        // header bit eight set: it must be ignored
        link_frame(1'b0, 16, {8'hA5, 3'b100, 4'h9, 1'b0});
        link_frame(1'b1, 10, {8'h3C, 3'b100, 4'h9, 1'b0});
        wr_b_q.push_back(13'({4'h9, 8'hB6}));
        link_frame(1'b1, 16, {8'hB6, 3'b100, 4'h9, 1'b0});
        link_frame(1'b1, 14, {8'h00, 3'b100, 4'h9, 1'b1});
        check_eq(13'(rd5), 13'h0016);
        check_eq(13'(oe6), 13'h001F);
        repeat (10) @(posedge i_sys_clk);
        check_eq(13'(wr_q.size() + wr_b_q.size() + hq.size()), 13'h0000);
        complete_run();
    end
endmodule : serial_command_port_header_tb

`default_nettype wire
